// *** hw/bir_pkg.sv ***
// Shared constants and types for the board interrupt router.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package bir_pkg;
    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    localparam int NSLOT = 3;
    localparam int NLINE = 4;
    localparam int NIRQ = 16;
    localparam int NPRIO = 15;
    localparam int NASYNC = 28;
    localparam int NPERIPH = 6;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef logic [3:0] bir_irq_sel_t;
    typedef logic [4:0] bir_vbase_t;
    typedef logic [NLINE-1:0] bir_pins_t;
    // --------------------------------------------------------------
    // Legacy IRQ numbers
    // --------------------------------------------------------------
    localparam bir_irq_sel_t IRQ_RTC = 4'h1;
    localparam bir_irq_sel_t IRQ_CASC = 4'h2;
    localparam bir_irq_sel_t IRQ_SER_LO = 4'h3;
    localparam bir_irq_sel_t IRQ_SER_HI = 4'h4;
    localparam bir_irq_sel_t IRQ_LPT_ALT = 4'h5;
    localparam bir_irq_sel_t IRQ_FDC = 4'h6;
    localparam bir_irq_sel_t IRQ_LPT = 4'h7;
    localparam bir_irq_sel_t IRQ_KBD = 4'hc;
    localparam bir_irq_sel_t IRQ_IDE_PRI = 4'he;
    // Peripheral enable bit positions
    localparam int PE_SER_A = 0;
    localparam int PE_SER_B = 1;
    localparam int PE_LPT = 2;
    localparam int PE_FDC = 3;
    localparam int PE_KBD = 4;
    localparam int PE_RTC = 5;
    // Fixed priority, highest first; slave IRQs 8-15 sit at the cascade slot
    localparam bir_irq_sel_t PRIO [NPRIO] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha,
        4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    // Reset values
    localparam logic [7:0] RST_VECTOR = 8'h00;
    localparam bir_pins_t RST_LINES_N = 4'hf;
    // Slot pin feeding shared line l on slot s (rotated wiring)
    function automatic int slot_pin(input int l, input int s);
        return (l + s) % NLINE;
    endfunction : slot_pin
endpackage : bir_pkg

// *** hw/bir_pic_if.sv ***
// Carrier between the router top and its compatibility controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface bir_pic_if;
    import bir_pkg::*;
    logic [NIRQ-1:0] irq_req;
    logic [NIRQ-1:0] level_mode;
    logic [NIRQ-1:0] mask;
    bir_vbase_t vbase_m;
    bir_vbase_t vbase_s;
    logic inta;
    logic eoi;
    logic intr;
    logic [7:0] vector;
    logic vec_valid;
    modport router (output irq_req, level_mode, mask, vbase_m, vbase_s, inta, eoi,
                    input intr, vector, vec_valid);
    modport pic (input irq_req, level_mode, mask, vbase_m, vbase_s, inta, eoi,
                 output intr, vector, vec_valid);
endinterface : bir_pic_if
`default_nettype wire

// *** hw/bir_pic.sv ***
// Pair of cascaded compatibility interrupt controllers, fixed priority.
// Assumes requests are already synchronised to i_clk.
`timescale 1ns/1ps
`default_nettype none
module bir_pic (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Router side
    bir_pic_if.pic pi
);
    import bir_pkg::*;

    logic [NIRQ-1:0] req_prev_q, irr_q, isr_q, edge_set, pending;
    logic hit, blocked, svc_hit, vec_valid_q;
    bir_irq_sel_t pick, svc;
    logic [7:0] vector_q;

    // --------------------------------------------------------------
    // Request latch
    // --------------------------------------------------------------
    assign edge_set = pi.irq_req & ~req_prev_q;
    assign pending = (pi.level_mode & pi.irq_req) | (~pi.level_mode & irr_q);

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            req_prev_q <= '0;
        else
            req_prev_q <= pi.irq_req;
    end

    // A new edge beats the acknowledge clearing the same bit
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            irr_q <= '0;
        else
        begin
            for (int i = 0; i < NIRQ; i++)
            begin
                if (edge_set[i])
                    irr_q[i] <= 1'b1; // see RULE_02
                else if (pi.inta && hit && pick == i[3:0])
                    irr_q[i] <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Priority resolve
    // --------------------------------------------------------------
    // An in-service line blocks itself and everything below it
    always_comb
    begin
        hit = 1'b0;
        blocked = 1'b0;
        pick = '0;
        svc_hit = 1'b0;
        svc = '0;
        for (int k = 0; k < NPRIO; k++)
        begin
            if (!svc_hit && isr_q[PRIO[k]])
            begin
                svc_hit = 1'b1;
                svc = PRIO[k];
            end
            if (!hit && !blocked)
            begin
                if (isr_q[PRIO[k]])
                begin
                    blocked = 1'b1;
                end
                else if (pending[PRIO[k]] && !pi.mask[PRIO[k]])
                begin
                    hit = 1'b1; // see RULE_02
                    pick = PRIO[k];
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Service tracking and vector
    // --------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            isr_q <= '0;
        else
        begin
            if (pi.eoi && svc_hit)
                isr_q[svc] <= 1'b0;
            if (pi.inta && hit)
                isr_q[pick] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            vector_q <= RST_VECTOR;
            vec_valid_q <= 1'b0;
        end
        else
        begin
            vec_valid_q <= pi.inta && hit;
            if (pi.inta && hit)
            begin
                vector_q <= pick[3] ? {pi.vbase_s, pick[2:0]} : {pi.vbase_m, pick[2:0]};
            end
        end
    end

    assign pi.intr = hit;
    assign pi.vector = vector_q;
    assign pi.vec_valid = vec_valid_q;
endmodule : bir_pic
`default_nettype wire

// *** hw/bir_top.sv ***
// Board interrupt router: shared PCI lines, IRQ steering, legacy
// controller pair and error delivery to the processor.
// Assumes requester pins are asynchronous; configuration inputs,
// acknowledge and end-of-interrupt come from logic on i_clk.
//
// Operation
// RULE_01: USB request is ORed onto shared line A.
// RULE_02: Provide a cascaded pair of compatible controllers on ISA IRQs.
// RULE_03: Each shared line steers to a configured ISA IRQ.
// RULE_04: Configuration picks the IRQ used by serial, parallel, floppy, keyboard; floppy (IRQ6) and keyboard (IRQ12) are fixed here, only enabled.
// RULE_05: NMI requests, parity, system and management errors reach SMI or NMI.
// RULE_06: NMI-type errors may appear as SMI; SMI events may become NMI.
// RULE_07: Line A from USB, slot 1 A, slot 2 B, slot 3 C.
// RULE_08: Line B from network, slot 1 B, slot 2 C, slot 3 D.
// RULE_09: Line C from SCSI, slot 1 C, slot 2 D, slot 3 A.
// RULE_10: Line D from slot 1 D, slot 2 A, slot 3 B only.
// RULE_11: Primary disk on IRQ14; secondary disk on the auxiliary line.
// RULE_12: Serial ports use IRQ3 and IRQ4, user chooses which.
// RULE_13: Parity and system errors always raise SMI.
// RULE_14: Video has no interrupt connection.
// RULE_15: Shared lines are active-low levels, released when all requesters release.
`timescale 1ns/1ps
`default_nettype none
module bir_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // PCI requesters, active low except USB
    input wire logic [bir_pkg::NSLOT-1:0][bir_pkg::NLINE-1:0] i_slot_int_n,
    input wire logic i_usb_irq,
    input wire logic i_lan_int_n,
    input wire logic i_scsi_int_n,
    // Embedded peripheral requests, active high
    input wire logic i_ser_a_irq,
    input wire logic i_ser_b_irq,
    input wire logic i_lpt_irq,
    input wire logic i_fdc_irq,
    input wire logic i_kbd_irq,
    input wire logic i_rtc_irq,
    input wire logic i_ide_pri_irq,
    input wire logic i_ide_sec_irq,
    // Error sources
    input wire logic i_nmi_req,
    input wire logic i_perr_n,
    input wire logic i_serr_n,
    input wire logic i_mgmt_err,
    input wire logic i_smi_event,
    // Steering configuration
    input wire logic [bir_pkg::NLINE-1:0] i_route_en,
    input wire bir_pkg::bir_irq_sel_t i_route_irq [bir_pkg::NLINE],
    input wire logic [bir_pkg::NPERIPH-1:0] i_periph_en,
    input wire logic i_ser_a_hi,
    input wire logic i_lpt_alt,
    input wire logic [bir_pkg::NIRQ-1:0] i_irq_level,
    input wire logic [bir_pkg::NIRQ-1:0] i_irq_mask,
    input wire bir_pkg::bir_vbase_t i_vbase_m,
    input wire bir_pkg::bir_vbase_t i_vbase_s,
    // Error delivery configuration
    input wire logic i_err_to_smi,
    input wire logic i_smi_to_nmi,
    // Processor side
    input wire logic i_inta,
    input wire logic i_eoi,
    output logic o_intr,
    output logic [7:0] o_vector,
    output logic o_vec_valid,
    output logic o_nmi,
    output logic o_smi_n,
    // Observed lines
    output logic [bir_pkg::NLINE-1:0] o_pci_int_n,
    output logic [bir_pkg::NIRQ-1:0] o_irq,
    output logic o_aux_irq_line_0
);
    import bir_pkg::*;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic [NASYNC-1:0] raw;
    logic [NASYNC-1:0] meta_q, sync_q;

    assign raw = {i_slot_int_n, i_usb_irq, i_lan_int_n, i_scsi_int_n,
                  i_ser_a_irq, i_ser_b_irq, i_lpt_irq, i_fdc_irq, i_kbd_irq,
                  i_rtc_irq, i_ide_pri_irq, i_ide_sec_irq,
                  i_nmi_req, i_perr_n, i_serr_n, i_mgmt_err, i_smi_event};

    // Idle values for every pin, so nothing fires out of reset
    localparam logic [NASYNC-1:0] RAW_IDLE = {{(NSLOT*NLINE){1'b1}}, 3'b011,
                                              8'h00, 5'b01100};

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta_q <= RAW_IDLE;
            sync_q <= RAW_IDLE;
        end
        else
        begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    logic [NSLOT-1:0][NLINE-1:0] slot_n;
    logic usb, lan_n, scsi_n, ser_a, ser_b, lpt, fdc, kbd, rtc, ide_pri, ide_sec;
    logic nmi_req, perr_n, serr_n, mgmt_err, smi_event;

    assign {slot_n, usb, lan_n, scsi_n, ser_a, ser_b, lpt, fdc, kbd, rtc, ide_pri,
            ide_sec, nmi_req, perr_n, serr_n, mgmt_err, smi_event} = sync_q;

    // --------------------------------------------------------------
    // Shared PCI lines
    // --------------------------------------------------------------
    // Onboard requester per line, active high; line D has none and the
    // video controller feeds no line at all
    logic [NLINE-1:0] onboard;
    logic [NLINE-1:0] line_act;

    assign onboard = {1'b0, ~scsi_n, ~lan_n, usb}; // see RULE_01 see RULE_14

    // Wired-OR of the rotated slot pins: line low while anyone holds it
    for (genvar l = 0; l < NLINE; l++)
    begin : g_line
        logic [NSLOT-1:0] slot_act;
        for (genvar s = 0; s < NSLOT; s++)
        begin : g_slot
            assign slot_act[s] = ~slot_n[s][slot_pin(l, s)]; // see RULE_07 see RULE_10
        end
        assign line_act[l] = onboard[l] | (|slot_act); // see RULE_08 see RULE_09
    end

    logic [NLINE-1:0] pci_int_n_q;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pci_int_n_q <= RST_LINES_N;
        else
            pci_int_n_q <= ~line_act; // see RULE_15
    end

    // --------------------------------------------------------------
    // IRQ assembly
    // --------------------------------------------------------------
    logic [NIRQ-1:0] irq_d, irq_q;
    logic aux_q;

    always_comb
    begin
        irq_d = '0;
        for (int l = 0; l < NLINE; l++)
        begin
            // Cascade input is never a steering target
            if (i_route_en[l] && i_route_irq[l] != IRQ_CASC && !pci_int_n_q[l])
                irq_d[i_route_irq[l]] = 1'b1; // see RULE_03
        end
        if (i_periph_en[PE_SER_A])
            irq_d[i_ser_a_hi ? IRQ_SER_HI : IRQ_SER_LO] |= ser_a; // see RULE_12
        if (i_periph_en[PE_SER_B])
            irq_d[i_ser_a_hi ? IRQ_SER_LO : IRQ_SER_HI] |= ser_b; // see RULE_12
        if (i_periph_en[PE_LPT])
            irq_d[i_lpt_alt ? IRQ_LPT_ALT : IRQ_LPT] |= lpt; // see RULE_04
        if (i_periph_en[PE_FDC])
            irq_d[IRQ_FDC] |= fdc; // see RULE_04
        if (i_periph_en[PE_KBD])
            irq_d[IRQ_KBD] |= kbd; // see RULE_04
        if (i_periph_en[PE_RTC])
            irq_d[IRQ_RTC] |= rtc;
        irq_d[IRQ_IDE_PRI] |= ide_pri; // see RULE_11
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            irq_q <= '0;
            aux_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
            aux_q <= ide_sec; // see RULE_11
        end
    end

    // --------------------------------------------------------------
    // Compatibility controller pair
    // --------------------------------------------------------------
    bir_pic_if pif ();

    assign pif.irq_req = irq_q;
    assign pif.level_mode = i_irq_level;
    assign pif.mask = i_irq_mask;
    assign pif.vbase_m = i_vbase_m;
    assign pif.vbase_s = i_vbase_s;
    assign pif.inta = i_inta;
    assign pif.eoi = i_eoi;

    bir_pic u_pic (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .pi(pif.pic)
    ); // see RULE_02

    // --------------------------------------------------------------
    // Error delivery
    // --------------------------------------------------------------
    // Levels, not pulses: the processor side latches the edge itself
    logic bus_err, classic, smi_d, nmi_d, smi_n_q, nmi_q;

    assign bus_err = ~perr_n | ~serr_n;
    assign classic = nmi_req | mgmt_err | bus_err;
    assign smi_d = bus_err | (i_err_to_smi & classic)
                 | (~i_smi_to_nmi & smi_event); // see RULE_13 see RULE_06
    assign nmi_d = (~i_err_to_smi & classic) | (i_smi_to_nmi & smi_event); // see RULE_05

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            smi_n_q <= 1'b1;
            nmi_q <= 1'b0;
        end
        else
        begin
            smi_n_q <= ~smi_d; // see RULE_05
            nmi_q <= nmi_d; // see RULE_06
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign o_intr = pif.intr;
    assign o_vector = pif.vector;
    assign o_vec_valid = pif.vec_valid;
    assign o_nmi = nmi_q;
    assign o_smi_n = smi_n_q;
    assign o_pci_int_n = pci_int_n_q;
    assign o_irq = irq_q;
    assign o_aux_irq_line_0 = aux_q;
endmodule : bir_top
`default_nettype wire

// *** dv/bir_top_props.sv ***
// Checker for the board interrupt router top.
// Assumes one clock domain and sees top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module bir_top_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Requesters
    input wire logic [bir_pkg::NSLOT-1:0][bir_pkg::NLINE-1:0] i_slot_int_n,
    input wire logic i_usb_irq,
    input wire logic i_lan_int_n,
    input wire logic i_scsi_int_n,
    input wire logic i_ser_a_irq,
    input wire logic i_ide_pri_irq,
    input wire logic i_ide_sec_irq,
    input wire logic i_nmi_req,
    input wire logic i_perr_n,
    input wire logic i_serr_n,
    input wire logic i_mgmt_err,
    input wire logic i_smi_event,
    // Configuration
    input wire logic [bir_pkg::NLINE-1:0] i_route_en,
    input wire bir_pkg::bir_irq_sel_t i_route_irq [bir_pkg::NLINE],
    input wire logic [bir_pkg::NPERIPH-1:0] i_periph_en,
    input wire logic i_ser_a_hi,
    input wire logic i_err_to_smi,
    input wire logic i_smi_to_nmi,
    // Processor side
    input wire logic i_inta,
    input wire logic o_intr,
    input wire logic o_vec_valid,
    input wire logic o_nmi,
    input wire logic o_smi_n,
    input wire logic [bir_pkg::NLINE-1:0] o_pci_int_n,
    input wire logic [bir_pkg::NIRQ-1:0] o_irq,
    input wire logic o_aux_irq_line_0
);
    import bir_pkg::*;
    // Old samples are only trusted once the synchronisers refilled
    logic [2:0] age_q;
    logic [4:0] err;
    logic smi_e;
    logic nmi_e;
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            age_q <= 3'h0;
        else if (age_q != 3'h4)
            age_q <= age_q + 3'h1;
    end
    assign err = {i_smi_event, i_mgmt_err, !i_serr_n, !i_perr_n, i_nmi_req};
    assign smi_e = err[1] | err[2] | (i_err_to_smi & |err[3:0]) | (!i_smi_to_nmi & err[4]);
    assign nmi_e = (!i_err_to_smi & |err[3:0]) | (i_smi_to_nmi & err[4]);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    sequence ack_taken;
        i_inta && o_intr;
    endsequence
    sequence vec_out;
        o_vec_valid;
    endsequence
    chk_line_a: assert property (
        age_q == 3'h4 |-> o_pci_int_n[0] == $past(!i_usb_irq
        & i_slot_int_n[0][0] & i_slot_int_n[1][1] & i_slot_int_n[2][2], 3))
        else $error("Shared line A wrong");
    chk_line_b: assert property (
        age_q == 3'h4 |-> o_pci_int_n[1] == $past(i_lan_int_n
        & i_slot_int_n[0][1] & i_slot_int_n[1][2] & i_slot_int_n[2][3], 3))
        else $error("Shared line B wrong");
    chk_line_c: assert property (
        age_q == 3'h4 |-> o_pci_int_n[2] == $past(i_scsi_int_n
        & i_slot_int_n[0][2] & i_slot_int_n[1][3] & i_slot_int_n[2][0], 3))
        else $error("Shared line C wrong");
    chk_line_d: assert property (
        age_q == 3'h4 |-> o_pci_int_n[3] ==
        $past(i_slot_int_n[0][3] & i_slot_int_n[1][0] & i_slot_int_n[2][1], 3))
        else $error("Shared line D wrong");
    chk_route_a: assert property (
        $past(!o_pci_int_n[0] && i_route_en[0]) && $stable(i_route_irq[0])
        && i_route_irq[0] != IRQ_CASC |-> o_irq[i_route_irq[0]])
        else $error("Steered IRQ missing");
    chk_ack_vector: assert property (ack_taken |=> vec_out)
        else $error("No vector after acknowledge");
    chk_vec_cause: assert property (vec_out |-> $past(i_inta && o_intr))
        else $error("Vector without acknowledge");
    chk_smi_map: assert property (
        age_q == 3'h4 |-> o_smi_n == !$past(smi_e, 3))
        else $error("SMI wrong");
    chk_nmi_map: assert property (
        age_q == 3'h4 |-> o_nmi == $past(nmi_e, 3))
        else $error("NMI wrong");
    chk_aux_line: assert property (
        age_q == 3'h4 |-> o_aux_irq_line_0 == $past(i_ide_sec_irq, 3))
        else $error("Aux line wrong");
    chk_disk_pri: assert property (
        age_q == 3'h4 && $past(i_ide_pri_irq, 3) |-> o_irq[IRQ_IDE_PRI])
        else $error("Primary disk IRQ missing");
    chk_serial_a: assert property (
        age_q == 3'h4 && $past(i_ser_a_irq, 3) && $past(i_periph_en[PE_SER_A])
        && $stable(i_ser_a_hi) |-> o_irq[i_ser_a_hi ? IRQ_SER_HI : IRQ_SER_LO])
        else $error("Serial IRQ missing");
endmodule : bir_top_props
bind bir_top bir_top_props u_props (
    .i_clk, .i_srst, .i_slot_int_n, .i_usb_irq, .i_lan_int_n, .i_scsi_int_n,
    .i_ser_a_irq, .i_ide_pri_irq, .i_ide_sec_irq, .i_nmi_req, .i_perr_n,
    .i_serr_n, .i_mgmt_err, .i_smi_event, .i_route_en, .i_route_irq,
    .i_periph_en, .i_ser_a_hi, .i_err_to_smi, .i_smi_to_nmi, .i_inta,
    .o_intr, .o_vec_valid, .o_nmi, .o_smi_n, .o_pci_int_n, .o_irq,
    .o_aux_irq_line_0
);
`default_nettype wire

// *** dv/bir_cpu_model.sv ***
// Processor model: acknowledges interrupts and ends each service.
// Assumes o_intr is settled by the falling edge.
`timescale 1ns/1ps
`default_nettype none
module bir_cpu_model (
    // Clock
    input wire logic i_clk,
    // From the router
    input wire logic i_intr,
    input wire logic i_vec_valid,
    // Answer delay in cycles
    input wire logic [3:0] i_slow,
    // To the router
    output logic o_inta,
    output logic o_eoi
);
    int wait_q = 0;
    initial
        {o_inta, o_eoi} = 2'h0;
    // ------------
    // Acknowledge
    // ------------
    // No new acknowledge while a vector or end of service is in flight
    always @(negedge i_clk)
    begin
        o_eoi <= i_vec_valid;
        if (o_inta)
            o_inta <= 1'h0;
        else if (i_intr && !i_vec_valid && !o_eoi)
        begin
            if (wait_q < int'(i_slow))
                wait_q <= wait_q + 1;
            else
            begin
                o_inta <= 1'h1;
                wait_q <= 0;
            end
        end
    end
endmodule : bir_cpu_model
`default_nettype wire

// *** dv/bir_top_bench.sv ***
// Self-checking bench for the board interrupt router.
// Assumes the processor model answers every interrupt it sees.
`timescale 1ns/1ps
`default_nettype none
module bir_top_bench;
    import bir_pkg::*;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic [NSLOT-1:0][NLINE-1:0] i_slot_int_n = '1;
    logic i_usb_irq = 1'h0;
    logic i_lan_int_n = 1'h1;
    logic i_scsi_int_n = 1'h1;
    logic [7:0] per = 8'h0;
    logic [4:0] err = 5'h0;
    logic [3:0] i_route_en = 4'h0;
    bir_irq_sel_t i_route_irq [NLINE] = '{default: 4'h9};
    logic [5:0] i_periph_en = 6'h3f;
    logic i_ser_a_hi = 1'h0;
    logic i_lpt_alt = 1'h0;
    logic [15:0] i_irq_mask = 16'h0;
    logic [15:0] lvl = 16'h0;
    bir_vbase_t i_vbase_m = 5'h0;
    bir_vbase_t i_vbase_s = 5'h0;
    logic i_err_to_smi = 1'h0;
    logic i_smi_to_nmi = 1'h0;
    logic i_inta, i_eoi, o_intr, o_vec_valid, o_nmi, o_smi_n, o_aux_irq_line_0;
    logic [7:0] o_vector;
    logic [3:0] o_pci_int_n;
    logic [15:0] o_irq;
    logic [3:0] slow = 4'h0;
    logic [31:0] seed = 32'h38a8;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] exp_q [$];
    bir_irq_sel_t tbl [4] = '{4'h9, 4'h5, 4'hb, 4'hf};
    logic [7:0] ptab [10] = '{8'h03, 8'h84, 8'h14, 8'h93, 8'h27, 8'ha5, 8'h36,
        8'h4c, 8'h51, 8'h6e};
    always #50 i_clk = ~i_clk;
    bir_top DUT (.i_clk, .i_srst, .i_slot_int_n, .i_usb_irq, .i_lan_int_n,
        .i_scsi_int_n, .i_ser_a_irq(per[0]), .i_ser_b_irq(per[1]), .i_lpt_irq(per[2]),
        .i_fdc_irq(per[3]), .i_kbd_irq(per[4]), .i_rtc_irq(per[5]),
        .i_ide_pri_irq(per[6]), .i_ide_sec_irq(per[7]), .i_nmi_req(err[0]),
        .i_perr_n(!err[1]), .i_serr_n(!err[2]), .i_mgmt_err(err[3]),
        .i_smi_event(err[4]), .i_route_en, .i_route_irq, .i_periph_en, .i_ser_a_hi,
        .i_lpt_alt, .i_irq_level(lvl), .i_irq_mask, .i_vbase_m, .i_vbase_s,
        .i_err_to_smi, .i_smi_to_nmi, .i_inta, .i_eoi, .o_intr, .o_vector,
        .o_vec_valid, .o_nmi, .o_smi_n, .o_pci_int_n, .o_irq, .o_aux_irq_line_0);
    bir_cpu_model u_cpu (.i_clk, .i_intr(o_intr), .i_vec_valid(o_vec_valid),
        .i_slow(slow), .o_inta(i_inta), .o_eoi(i_eoi));
    // ------------
    // Helpers
    // ------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] vec(input bir_irq_sel_t n);
        return n[3] ? {i_vbase_s, n[2:0]} : {i_vbase_m, n[2:0]};
    endfunction : vec
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic tally(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'h1)
        begin
            fails++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask : tally
    task automatic cmp_bit(input logic got, input logic exp);
        tally(got === exp, "level");
    endtask : cmp_bit
    task automatic cmp_lines(input logic [3:0] got, input logic [3:0] exp);
        tally(got === exp, "shared lines");
    endtask : cmp_lines
    task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, "vector");
    endtask : cmp_vec
    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask : step
    task automatic drain();
        int n = 0;
        while (exp_q.size() != 0 && n < 80)
        begin
            step(1);
            n++;
        end
        tally(exp_q.size() == 0, "vector missing");
    endtask : drain
    task automatic req(input int b, input bir_irq_sel_t n);
        slow = 4'(rnd() % 4);
        exp_q.push_back(vec(n));
        per[b] = 1'h1;
        drain();
        per[b] = 1'h0;
        step(6);
    endtask : req
    always @(negedge i_clk)
    begin
        if (!i_srst && o_vec_valid === 1'h1)
        begin
            if (exp_q.size() == 0)
                tally(1'h0, "unexpected vector");
            else
                cmp_vec(o_vector, exp_q.pop_front());
        end
    end
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            finish_test();
        end
    end
    // ------------
    // Scenarios
    // ------------
    initial
    begin
        logic sm;
        logic nm;
        i_vbase_m = 5'(rnd());
        i_vbase_s = 5'(rnd());
        step(2);
        i_srst = 1'h0;
        for (int l = 0; l < 4; l++)
        begin
            for (int s = 0; s < 3; s++)
            begin
                i_slot_int_n = ~(12'h1 << (s * 4 + (l + s) % 4));
                step(4);
                cmp_lines(o_pci_int_n, 4'hf ^ (4'h1 << l));
                cmp_bit(o_intr, 1'h0);
            end
        end
        {i_usb_irq, i_lan_int_n, i_scsi_int_n} = 3'h4;
        i_slot_int_n = 12'hffe;
        step(4);
        cmp_lines(o_pci_int_n, 4'h8);
        {i_usb_irq, i_lan_int_n, i_scsi_int_n} = 3'h3;
        step(4);
        cmp_lines(o_pci_int_n, 4'he);
        i_slot_int_n = '1;
        step(4);
        cmp_lines(o_pci_int_n, 4'hf);
        for (int l = 0; l < 4; l++)
        begin
            i_route_irq[l] = tbl[l];
            i_route_en = 4'h1 << l;
            step(2);
            exp_q.push_back(vec(tbl[l]));
            i_slot_int_n[0][l] = 1'h0;
            drain();
            i_slot_int_n = '1;
            step(6);
        end
        i_route_irq[0] = IRQ_CASC;
        i_route_en = 4'h1;
        i_slot_int_n[0][0] = 1'h0;
        step(8);
        cmp_bit(o_intr, 1'h0);
        i_slot_int_n = '1;
        i_route_en = 4'h0;
        step(6);
        foreach (ptab[i])
        begin
            {i_ser_a_hi, i_lpt_alt} = {2{ptab[i][7]}};
            step(2);
            req(int'(ptab[i][6:4]), ptab[i][3:0]);
        end
        exp_q.push_back(vec(IRQ_IDE_PRI));
        exp_q.push_back(vec(IRQ_SER_LO));
        per = 8'h41;
        drain();
        per = 8'h0;
        step(6);
        lvl = 16'h0040;
        repeat (2) exp_q.push_back(vec(IRQ_FDC));
        per = 8'h08;
        drain();
        i_irq_mask = 16'h0040;
        per = 8'h0;
        step(6);
        {lvl, i_irq_mask} = 32'h0;
        i_periph_en = 6'h3e;
        per = 8'h81;
        step(6);
        cmp_bit(o_intr, 1'h0);
        cmp_bit(o_aux_irq_line_0, 1'h1);
        per = 8'h0;
        step(6);
        i_periph_en = 6'h3f;
        i_irq_mask = 16'h0008;
        per = 8'h01;
        step(6);
        cmp_bit(o_irq[3], 1'h1);
        cmp_bit(o_intr, 1'h0);
        // A masked edge stays latched, so a reset clears it out
        i_srst = 1'h1;
        step(2);
        cmp_bit(o_irq[3], 1'h0);
        cmp_vec(o_vector, 8'h0);
        per = 8'h0;
        i_irq_mask = 16'h0;
        i_srst = 1'h0;
        step(6);
        for (int c = 0; c < 4; c++)
        begin
            {i_err_to_smi, i_smi_to_nmi} = 2'(c);
            step(4);
            for (int e = 0; e < 5; e++)
            begin
                err = 5'h1 << e;
                sm = e == 1 || e == 2 || (i_err_to_smi && e < 4) || (!i_smi_to_nmi && e == 4);
                nm = (!i_err_to_smi && e < 4) || (i_smi_to_nmi && e == 4);
                step(4);
                cmp_bit(o_smi_n, !sm);
                cmp_bit(o_nmi, nm);
                err = 5'h0;
                step(4);
            end
        end
        finish_test();
    end
endmodule : bir_top_bench
`default_nettype wire
